/* logic/dma_chan_irq.sv */
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module dma_chan_irq
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [dma_chan_irq_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [dma_chan_irq_pkg::STRB_W-1:0] pstrb_i,
  input wire logic [dma_chan_irq_pkg::DATA_W-1:0] pwdata_i,
  output logic [dma_chan_irq_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [dma_chan_irq_pkg::SIZE_W-1:0] src_ptr_i,
  input wire logic [dma_chan_irq_pkg::SIZE_W-1:0] dst_ptr_i,
  input wire logic [dma_chan_irq_pkg::SIZE_W-1:0] cell_cnt_i,
  input wire logic [dma_chan_irq_pkg::SIZE_W-1:0] block_cnt_i,
  input wire logic pattern_match_i,
  input wire logic addr_error_i,
  input wire logic irq_valid_i,
  input wire logic [dma_chan_irq_pkg::IRQ_W-1:0] irq_num_i,
  output logic abort_xfer_o,
  output logic [dma_chan_irq_pkg::DATA_W-1:0] src_start_addr_o,
  output logic chan_irq_o
);

  // =====================================================================
  // register state
  // =====================================================================
  dma_chan_irq_pkg::chan_flags_t flags_ff; // sticky event flags
  dma_chan_irq_pkg::chan_flags_t ie_ff;    // per-flag enables
  logic [dma_chan_irq_pkg::IRQ_W-1:0] asel_ff; // abort interrupt number
  logic aen_ff;                                // abort interrupt enable
  logic [dma_chan_irq_pkg::DATA_W-1:0] ssa_ff; // source start address
  logic [dma_chan_irq_pkg::SIZE_W-1:0] src_size_ff;
  logic [dma_chan_irq_pkg::SIZE_W-1:0] dst_size_ff;
  logic [dma_chan_irq_pkg::SIZE_W-1:0] cell_size_ff;
  logic [dma_chan_irq_pkg::DATA_W-1:0] prdata_ff; // captured read word
  logic rd_ok_ff;                                 // read word is ready
  logic abort_ff;                                 // abort pulse to datapath

  // =====================================================================
  // apb decode
  // =====================================================================
  dma_chan_irq_pkg::apb_req_t req; // bundled request
  logic [dma_chan_irq_pkg::DATA_W-1:0] bmask; // byte-lane write mask
  logic hit_ctrl, hit_ssa, hit_evt, hit_ssz, hit_dsz, hit_csz, hit_ptr;
  logic addr_hit; // any mapped word
  logic acc;      // access phase completing this cycle
  logic wr;       // write takes effect
  logic rd_load;  // read word capture

  assign req = '{addr: paddr_i, write: pwrite_i, strb: pstrb_i, wdata: pwdata_i};

  // expand byte strobes to a bit mask
  genvar gl;
  generate
    for (gl = 0; gl < dma_chan_irq_pkg::STRB_W; gl++)
    begin : g_lane
      assign bmask[gl*8 +: 8] = {8{req.strb[gl]}};
    end
  endgenerate

  assign hit_ctrl = (req.addr == dma_chan_irq_pkg::OFS_INT_CTRL);
  assign hit_ssa = (req.addr == dma_chan_irq_pkg::OFS_SRC_START);
  assign hit_evt = (req.addr == dma_chan_irq_pkg::OFS_EVT_CTRL);
  assign hit_ssz = (req.addr == dma_chan_irq_pkg::OFS_SRC_SIZE);
  assign hit_dsz = (req.addr == dma_chan_irq_pkg::OFS_DST_SIZE);
  assign hit_csz = (req.addr == dma_chan_irq_pkg::OFS_CELL_SIZE);
  assign hit_ptr = (req.addr == dma_chan_irq_pkg::OFS_POINTERS);
  assign addr_hit = hit_ctrl | hit_ssa | hit_evt | hit_ssz | hit_dsz | hit_csz | hit_ptr;

  // writes need no wait; reads need none either, the word being captured in the setup cycle
  assign pready_o = ce_i && psel_i && penable_i && (req.write || rd_ok_ff);
  assign pslverr_o = pready_o && !addr_hit;
  assign acc = pready_o;
  assign wr = acc && req.write && addr_hit;
  assign rd_load = ce_i && psel_i && !req.write && !rd_ok_ff;

  // =====================================================================
  // read mux; unimplemented bits read zero
  // =====================================================================
  logic [dma_chan_irq_pkg::DATA_W-1:0] word_ctrl, word_evt, word_ptr, rd_mux;

  assign word_ctrl = {8'h00, ie_ff, 8'h00, flags_ff};
  assign word_evt = (32'(asel_ff) << dma_chan_irq_pkg::ASEL_LSB)
                  | (32'(aen_ff) << dma_chan_irq_pkg::AEN_BIT);
  assign word_ptr = (32'(dst_ptr_i) << dma_chan_irq_pkg::PTR_DST_LSB) | 32'(src_ptr_i);
  assign rd_mux = hit_ctrl ? word_ctrl
                : hit_ssa ? ssa_ff
                : hit_evt ? word_evt
                : hit_ssz ? 32'(src_size_ff)
                : hit_dsz ? 32'(dst_size_ff)
                : hit_csz ? 32'(cell_size_ff)
                : hit_ptr ? word_ptr
                : dma_chan_irq_pkg::RST_WORD;

  // read capture: load once per transfer, release on completion
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prdata_ff <= dma_chan_irq_pkg::RST_WORD;
      rd_ok_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (rd_load)
      begin
        prdata_ff <= rd_mux;
        rd_ok_ff <= 1'b1;
      end
      else if (acc || !psel_i)
        rd_ok_ff <= 1'b0;
    end
  end

  assign prdata_o = prdata_ff;

  // =====================================================================
  // configuration registers
  // =====================================================================
  logic [dma_chan_irq_pkg::DATA_W-1:0] nxt_ssa; // source start address merge

  // physical address is software's duty; hardware only stores it
  assign nxt_ssa = (ssa_ff & ~bmask) | (req.wdata & bmask);

  // enables, abort setup, start address and sizes
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ie_ff <= dma_chan_irq_pkg::RST_IE;
      asel_ff <= dma_chan_irq_pkg::RST_ASEL;
      aen_ff <= dma_chan_irq_pkg::RST_AEN;
      ssa_ff <= dma_chan_irq_pkg::RST_WORD;
      src_size_ff <= dma_chan_irq_pkg::RST_SIZE;
      dst_size_ff <= dma_chan_irq_pkg::RST_SIZE;
      cell_size_ff <= dma_chan_irq_pkg::RST_SIZE;
    end
    else if (ce_i && wr)
    begin
      if (hit_ctrl && req.strb[dma_chan_irq_pkg::IE_LANE])
        ie_ff <= req.wdata[dma_chan_irq_pkg::IE_LSB +: dma_chan_irq_pkg::NUM_EVT];
      if (hit_evt && req.strb[dma_chan_irq_pkg::ASEL_LANE])
        asel_ff <= req.wdata[dma_chan_irq_pkg::ASEL_LSB +: dma_chan_irq_pkg::IRQ_W];
      if (hit_evt && req.strb[dma_chan_irq_pkg::AEN_LANE])
        aen_ff <= req.wdata[dma_chan_irq_pkg::AEN_BIT];
      if (hit_ssa)
        ssa_ff <= nxt_ssa;
      if (hit_ssz)
        src_size_ff <= (src_size_ff & ~bmask[15:0]) | (req.wdata[15:0] & bmask[15:0]);
      if (hit_dsz)
        dst_size_ff <= (dst_size_ff & ~bmask[15:0]) | (req.wdata[15:0] & bmask[15:0]);
      if (hit_csz)
        cell_size_ff <= (cell_size_ff & ~bmask[15:0]) | (req.wdata[15:0] & bmask[15:0]);
    end
  end

  assign src_start_addr_o = ssa_ff;

  // =====================================================================
  // pointer comparators
  // =====================================================================
  logic [dma_chan_irq_pkg::SIZE_W-1:0] cmp_cur [dma_chan_irq_pkg::NUM_MATCH];
  logic [dma_chan_irq_pkg::SIZE_W-1:0] cmp_tgt [dma_chan_irq_pkg::NUM_MATCH];
  logic [dma_chan_irq_pkg::NUM_MATCH-1:0] cmp_hit; // one-shot hits
  logic [dma_chan_irq_pkg::SIZE_W-1:0] big_size;   // larger of the two sizes

  assign big_size = (src_size_ff > dst_size_ff) ? src_size_ff : dst_size_ff;
  assign cmp_cur[0] = src_ptr_i;
  assign cmp_tgt[0] = src_size_ff;
  assign cmp_cur[1] = src_ptr_i;
  assign cmp_tgt[1] = src_size_ff >> 1;
  assign cmp_cur[2] = dst_ptr_i;
  assign cmp_tgt[2] = dst_size_ff;
  assign cmp_cur[3] = dst_ptr_i;
  assign cmp_tgt[3] = dst_size_ff >> 1;
  assign cmp_cur[4] = block_cnt_i;
  assign cmp_tgt[4] = big_size;
  assign cmp_cur[5] = cell_cnt_i;
  assign cmp_tgt[5] = cell_size_ff;

  genvar gm;
  generate
    for (gm = 0; gm < dma_chan_irq_pkg::NUM_MATCH; gm++)
    begin : g_match
      match_pulse u_match
      (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .cur_i(cmp_cur[gm]),
        .tgt_i(cmp_tgt[gm]),
        .hit_o(cmp_hit[gm])
      );
    end
  endgenerate

  // =====================================================================
  // abort detection
  // =====================================================================
  logic abort_hit; // selected number seen while enabled

  // any of the 256 numbers may be chosen; disabled means fully ignored
  assign abort_hit = aen_ff && irq_valid_i && (irq_num_i == asel_ff);

  // one-cycle abort request toward the transfer engine
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      abort_ff <= 1'b0;
    else if (ce_i)
      abort_ff <= abort_hit;
  end

  assign abort_xfer_o = abort_ff;

  // =====================================================================
  // sticky flags and interrupt
  // =====================================================================
  dma_chan_irq_pkg::chan_flags_t flag_set, flag_clr, nxt_flags;

  assign flag_set = '{src_done: cmp_hit[0],
                      src_half: cmp_hit[1],
                      dst_done: cmp_hit[2],
                      dst_half: cmp_hit[3],
                      block_done: cmp_hit[4] | pattern_match_i,
                      cell_done: cmp_hit[5],
                      abort: abort_hit,
                      addr_error: addr_error_i};
  // writing zero clears, writing one leaves the flag alone
  assign flag_clr = (wr && hit_ctrl && req.strb[dma_chan_irq_pkg::FLAG_LANE])
                  ? ~req.wdata[dma_chan_irq_pkg::FLAG_LSB +: dma_chan_irq_pkg::NUM_EVT]
                  : dma_chan_irq_pkg::RST_FLAGS;
  // a new event in the clearing cycle is kept
  assign nxt_flags = flag_set | (flags_ff & ~flag_clr);

  // flag register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      flags_ff <= dma_chan_irq_pkg::RST_FLAGS;
    else if (ce_i)
      flags_ff <= nxt_flags;
  end

  assign chan_irq_o = |(flags_ff & ie_ff);

  // =====================================================================
  // checks
  // =====================================================================
  a_irq_tracks_enables: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && (|(flag_set & ie_ff)) && !(wr && hit_ctrl) |=> chan_irq_o)
    else $error("enabled event did not raise the interrupt");

  a_abort_sets_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && aen_ff && irq_valid_i && irq_num_i == asel_ff |=> flags_ff.abort && abort_xfer_o)
    else $error("matching abort number did not abort");

  a_abort_disabled: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !aen_ff |=> !abort_xfer_o)
    else $error("abort fired while disabled");

  a_ctrl_reserved: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_load && hit_ctrl |=> prdata_o[31:24] == 8'h00 && prdata_o[15:8] == 8'h00)
    else $error("reserved control bits not zero");

  a_ie_reset_zero: assert property (@(posedge clk_i)
    !rst_n_i |=> ie_ff == dma_chan_irq_pkg::RST_IE && !chan_irq_o)
    else $error("enables not cleared by reset");

  a_src_done_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && src_size_ff != 16'h0000 && src_ptr_i == src_size_ff && !$past(src_ptr_i == src_size_ff)
    && $stable(src_size_ff) |=> flags_ff.src_done)
    else $error("source done not flagged");

  a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flags_ff.addr_error && !(wr && hit_ctrl) |=> flags_ff.addr_error)
    else $error("flag dropped without a clearing write");

  a_set_beats_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && addr_error_i |=> flags_ff.addr_error)
    else $error("address error lost");

  a_pattern_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && pattern_match_i |=> flags_ff.block_done ##1 flags_ff.block_done || $past(wr))
    else $error("pattern match did not flag block end");

endmodule

/* logic/dma_chan_irq_pkg.sv */
package dma_chan_irq_pkg;

  // =====================================================================
  // bus geometry
  // =====================================================================
  localparam int unsigned ADDR_W = 8;  // byte address bits decoded
  localparam int unsigned DATA_W = 32; // apb data width
  localparam int unsigned STRB_W = 4;  // byte lanes
  localparam int unsigned SIZE_W = 16; // size, pointer and count width
  localparam int unsigned IRQ_W = 8;   // interrupt number width
  localparam int unsigned NUM_EVT = 8; // flags in the control register
  localparam int unsigned NUM_MATCH = 6; // pointer comparators

  // =====================================================================
  // register offsets (byte addresses)
  // =====================================================================
  localparam logic [ADDR_W-1:0] OFS_INT_CTRL = 8'h00;  // channel_interrupt_control
  localparam logic [ADDR_W-1:0] OFS_SRC_START = 8'h04; // channel_source_start_address
  localparam logic [ADDR_W-1:0] OFS_EVT_CTRL = 8'h08;  // abort select and enable
  localparam logic [ADDR_W-1:0] OFS_SRC_SIZE = 8'h0C;  // source_size
  localparam logic [ADDR_W-1:0] OFS_DST_SIZE = 8'h10;  // destination_size
  localparam logic [ADDR_W-1:0] OFS_CELL_SIZE = 8'h14; // cell_size
  localparam logic [ADDR_W-1:0] OFS_POINTERS = 8'h18;  // live pointers, read only

  // =====================================================================
  // field positions
  // =====================================================================
  localparam int unsigned FLAG_LSB = 0;   // flags, bits 7..0
  localparam int unsigned IE_LSB = 16;    // enables, bits 23..16
  localparam int unsigned ASEL_LSB = 16;  // abort_irq_select, bits 23..16
  localparam int unsigned AEN_BIT = 3;    // abort_irq_enable
  localparam int unsigned PTR_DST_LSB = 16; // destination_pointer in pointer word
  localparam int unsigned FLAG_LANE = 0;  // byte lane of the flags
  localparam int unsigned IE_LANE = 2;    // byte lane of the enables
  localparam int unsigned ASEL_LANE = 2;  // byte lane of the abort select
  localparam int unsigned AEN_LANE = 0;   // byte lane of the abort enable

  // =====================================================================
  // reset values
  // =====================================================================
  localparam logic [NUM_EVT-1:0] RST_FLAGS = 8'h00;
  localparam logic [NUM_EVT-1:0] RST_IE = 8'h00;
  localparam logic [IRQ_W-1:0] RST_ASEL = 8'hFF;
  localparam logic RST_AEN = 1'b0;
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [SIZE_W-1:0] RST_SIZE = 16'h0000;

  // =====================================================================
  // carriers
  // =====================================================================
  // flag and enable layout, msb first as in the control register
  typedef struct packed {
    logic src_done;
    logic src_half;
    logic dst_done;
    logic dst_half;
    logic block_done;
    logic cell_done;
    logic abort;
    logic addr_error;
  } chan_flags_t;

  // one apb request as seen by the slave
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [STRB_W-1:0] strb;
    logic [DATA_W-1:0] wdata;
  } apb_req_t;

endpackage

/* logic/match_pulse.sv */
`timescale 1ns/1ps
// =====================================================================
// one-shot compare: pulses once when cur first equals a nonzero target
// =====================================================================
module match_pulse
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [dma_chan_irq_pkg::SIZE_W-1:0] cur_i,
  input wire logic [dma_chan_irq_pkg::SIZE_W-1:0] tgt_i,
  output logic hit_o
);

  logic eq_ff; // equality seen last cycle
  logic eq;    // equality now

  // a zero target is treated as unprogrammed so reset pointers do not fire
  assign eq = (cur_i == tgt_i) && (tgt_i != '0);

  // rising edge only, so a flag cleared while the pointer rests does not re-set
  assign hit_o = eq && !eq_ff;

  // previous-match register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      eq_ff <= 1'b0;
    else if (ce_i)
      eq_ff <= eq;
  end

endmodule

/* verif/dma_far_model.sv */
`timescale 1ns/1ps
// =====================================================================
// datapath stand-in: walks all pointers and counts up together
// =====================================================================
module dma_far_model
#(
  parameter int unsigned LIMIT = 24 // last count of a full transfer
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic stop_i,
  output logic [dma_chan_irq_pkg::SIZE_W-1:0] count_o
);
  logic busy_ff; // transfer in progress

  // one shared count keeps the expected flags easy to derive
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      count_o <= 16'h0000;
      busy_ff <= 1'b0;
    end
    else if (start_i)
    begin
      count_o <= 16'h0000;
      busy_ff <= 1'b1;
    end
    else if (stop_i)
      busy_ff <= 1'b0;
    else if (busy_ff)
    begin
      count_o <= count_o + 16'h0001;
      // stop at the end, pointers then hold still
      if (count_o == 16'(LIMIT - 1))
        busy_ff <= 1'b0;
    end
  end
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  // =====================================================================
  // signals
  // =====================================================================
  logic clk_i, rst_n, ce, psel, pen, pwr, pready, pslverr, go, pm, ae, irq_v;
  logic [7:0] paddr, irq_n, ie, sel;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, sa, src_start;
  logic [15:0] cnt;
  logic abort, chan_irq;
  logic [32:0] exp_q[$]; // oldest pending read: {pslverr, prdata}
  logic [32:0] exp_w;
  int n_fail = 0;
  int total_checks = 0;

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    {rst_n, psel, pen, pwr, go, pm, ae, irq_v} = '0;
    ce = 1'b1; // high except in the freeze scenario
    {paddr, irq_n, pstrb, pwdata} = '0;
  end

  // =====================================================================
  // design and far side
  // =====================================================================
  dma_chan_irq dut (.clk_i(clk_i), .rst_n_i(rst_n), .ce_i(ce), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pstrb_i(pstrb), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .src_ptr_i(cnt), .dst_ptr_i(cnt), .cell_cnt_i(cnt),
    .block_cnt_i(cnt), .pattern_match_i(pm), .addr_error_i(ae), .irq_valid_i(irq_v),
    .irq_num_i(irq_n), .abort_xfer_o(abort), .src_start_addr_o(src_start), .chan_irq_o(chan_irq));

  dma_far_model #(.LIMIT(24)) far (.clk_i(clk_i), .rst_n_i(rst_n), .start_i(go), .stop_i(abort),
    .count_o(cnt));

  // =====================================================================
  // helpers
  // =====================================================================
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  // one apb transfer; pready is sampled at the rising edge that completes it
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
           input logic [32:0] e);
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    if (!w)
      exp_q.push_back(e);
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s, 33'h0);
  endtask

  task rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, 4'hF, e);
  endtask

  // one interrupt number occurrence, optionally starting a transfer alongside
  task fire(input logic [7:0] n, input logic g, input logic exp);
    @(posedge clk_i);
    irq_v <= 1'b1;
    irq_n <= n;
    go <= g;
    @(posedge clk_i);
    irq_v <= 1'b0;
    go <= 1'b0;
    #1;
    chk(abort, exp, "abort pulse");
  endtask

  // read scoreboard: the oldest note meets the completing read
  always @(posedge clk_i)
  begin
    if (psel && pen && !pwr && pready === 1'b1 && exp_q.size() > 0)
    begin
      exp_w = exp_q.pop_front();
      total_checks++;
      if ({pslverr, prdata} !== exp_w)
      begin
        n_fail++;
        $display("BAD %0t read %h expected %h", $time, {pslverr, prdata}, exp_w);
      end
    end
  end

  // hang guard, far above the few hundred cycles used
  initial
  begin
    #200000;
    n_fail++;
    finish_test;
  end

  // =====================================================================
  // main sequence
  // =====================================================================
  initial
  begin
    void'($urandom(54563));
    repeat (20) @(posedge clk_i);
    rst_n <= 1'b1;
    rd(dma_chan_irq_pkg::OFS_INT_CTRL, 33'h0);
    rd(dma_chan_irq_pkg::OFS_EVT_CTRL, {1'b0, 32'h00FF_0000});
    rd(8'h1C, {1'b1, 32'h0}); // unmapped place
    wr(dma_chan_irq_pkg::OFS_INT_CTRL, 32'hFFFF_FF00, 4'hF);
    rd(dma_chan_irq_pkg::OFS_INT_CTRL, {1'b0, 32'h00FF_0000});
    ie = 8'($urandom);
    wr(dma_chan_irq_pkg::OFS_INT_CTRL, {8'h00, ie, 16'h0000}, 4'h4);
    sa = $urandom;
    wr(dma_chan_irq_pkg::OFS_SRC_START, sa, 4'hF);
    rd(dma_chan_irq_pkg::OFS_SRC_START, {1'b0, sa});
    chk(src_start === sa, 1'b1, "start address out");
    // source 16, destination 20, cell 4: all six pointer events land
    wr(dma_chan_irq_pkg::OFS_SRC_SIZE, 32'h0000_0010, 4'hF);
    wr(dma_chan_irq_pkg::OFS_DST_SIZE, 32'h0000_0014, 4'hF);
    wr(dma_chan_irq_pkg::OFS_CELL_SIZE, 32'h0000_0004, 4'hF);
    fire(8'h00, 1'b1, 1'b0);
    repeat (30) @(posedge clk_i);
    rd(dma_chan_irq_pkg::OFS_INT_CTRL, {1'b0, 8'h00, ie, 16'h00FC});
    rd(dma_chan_irq_pkg::OFS_INT_CTRL, {1'b0, 8'h00, ie, 16'h00FC});
    // both pointers rest at the last count of the transfer
    rd(dma_chan_irq_pkg::OFS_POINTERS, {1'b0, 32'h0018_0018});
    rd(dma_chan_irq_pkg::OFS_SRC_SIZE, {1'b0, 32'h0000_0010});
    chk(chan_irq, |(ie & 8'hFC), "irq level after run");
    wr(dma_chan_irq_pkg::OFS_INT_CTRL, 32'h0, 4'h1);
    rd(dma_chan_irq_pkg::OFS_INT_CTRL, {1'b0, 8'h00, ie, 16'h0000});
    chk(chan_irq, 1'b0, "irq after clear");
    // frozen clock enable: events seen while it is low are dropped
    @(posedge clk_i);
    ce <= 1'b0;
    pm <= 1'b1;
    ae <= 1'b1;
    @(posedge clk_i);
    ce <= 1'b1;
    pm <= 1'b0;
    ae <= 1'b0;
    rd(dma_chan_irq_pkg::OFS_INT_CTRL, {1'b0, 8'h00, ie, 16'h0000});
    chk(chan_irq, 1'b0, "irq after frozen events");
    // pattern match and address error in the same cycle
    @(posedge clk_i);
    pm <= 1'b1;
    ae <= 1'b1;
    @(posedge clk_i);
    pm <= 1'b0;
    ae <= 1'b0;
    rd(dma_chan_irq_pkg::OFS_INT_CTRL, {1'b0, 8'h00, ie, 16'h0009});
    chk(chan_irq, |(ie & 8'h09), "irq level events");
    wr(dma_chan_irq_pkg::OFS_INT_CTRL, 32'h0, 4'h1);
    // abort numbers: both ends of the range and one random
    for (int i = 0; i < 3; i++)
    begin
      sel = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      wr(dma_chan_irq_pkg::OFS_EVT_CTRL, {8'h00, sel, 16'h0000}, 4'hF);
      fire(sel, 1'b0, 1'b0);
      wr(dma_chan_irq_pkg::OFS_EVT_CTRL, {8'h00, sel, 16'h0008}, 4'hF);
      fire(sel ^ 8'h01, 1'b0, 1'b0);
      // abort lands one cycle after the start, before the first count and any pointer event
      fire(sel, 1'b1, 1'b1);
      repeat (30) @(posedge clk_i);
      rd(dma_chan_irq_pkg::OFS_INT_CTRL, {1'b0, 8'h00, ie, 16'h0002});
      chk(chan_irq, ie[1], "irq level abort");
      wr(dma_chan_irq_pkg::OFS_INT_CTRL, 32'h0, 4'h1);
    end
    // second reset while no transfer runs, with a flag pending: all returns to reset values
    @(posedge clk_i);
    ae <= 1'b1;
    @(posedge clk_i);
    ae <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n <= 1'b1;
    rd(dma_chan_irq_pkg::OFS_INT_CTRL, 33'h0);
    rd(dma_chan_irq_pkg::OFS_EVT_CTRL, {1'b0, 32'h00FF_0000});
    chk(chan_irq, 1'b0, "irq after reset");
    chk(src_start === 32'h0000_0000, 1'b1, "start address after reset");
    finish_test;
  end
endmodule
